//--- hw/nic_ctrl.sv
// nested interrupt controller: pending latches, arbitration, entry and return
`timescale 1ns/100ps
// How it works
// - finish current instruction before entering handler
// - push PC, X, A and CC
// - load CC priority from vector field
// - bits 5,3 encode levels 10,01,00,11
// - load vector address, start handler fetch
// - return pops context including priority bits
// - vectors fixed from FFE0h to FFFFh
// - up to 16 vectors, 4 levels
// - highest software level wins first
// - ties broken by fixed hardware order
// - unserviced requests stay latched
// - reset and trap ignore mask, set level 3
// - trap instruction raises the trap
// - maskable needs enable and strictly higher level
// - edge latch cleared on handler entry
// - selected pins of a group ORed
// - peripheral request needs flag and enable
// - clearing sequence drops the pending latch
// - wait wakes on any, halt on capable
// - non-capable pending serviced right after first
// - CC resets to 111x 1010
// - level 3 blocks maskable, not trap
// - level 0 writes to priority fields ignored
// - priority registers reset to FFh
module nic_ctrl import nic_pkg::*; #(
  parameter logic [NUM_VEC-1:0] EDGE_MASK = EDGE_MASK_DEF,
  parameter logic [NUM_VEC-1:0] HALT_MASK = HALT_MASK_DEF
) (
  input wire logic sys_clk, // cpu clock
  input wire logic reset, // async reset, active high
  input wire logic [EXT_LINES*PINS_PER_LINE-1:0] ext_pin, // external pins, async
  input wire logic [EXT_LINES*PINS_PER_LINE-1:0] ext_pin_sel, // pin selected onto its line
  input wire logic [NUM_VEC-1:0] periph_flag, // peripheral status flags
  input wire logic [NUM_VEC-1:0] periph_en, // peripheral enable bits
  input wire logic [NUM_VEC-1:0] periph_clr, // clearing sequence done, pulse
  input wire logic [NUM_VEC-1:0] vec_en, // vector enabled for service
  input wire logic instr_done, // current instruction completes, pulse
  input wire logic trap_exec, // trap instruction executed, pulse
  input wire logic return_from_handler_instr_exec, // return instruction executed, pulse
  input wire logic wait_mode, // cpu in wait mode
  input wire logic halt_mode, // cpu in halt mode
  input wire logic cc_wr, // cpu writes condition code
  input wire logic [7:0] cc_wdata, // condition code write value
  input wire logic [7:0] pop_data, // byte popped from stack
  input wire logic prio_wr, // priority register write strobe
  input wire logic [PRIO_REG_IDX_W-1:0] prio_addr, // priority register index
  input wire logic [7:0] prio_wdata, // priority register write data
  output logic [7:0] prio_rdata_r, // priority register read data
  output logic [7:0] condition_code_reg, // condition code register
  output logic stack_push_r, // push one context byte
  output logic stack_pop_r, // pop one context byte
  output logic [2:0] stack_sel_r, // which context byte
  output logic vec_load_r, // load pc with vector, pulse
  output logic [15:0] vec_addr_r, // vector address
  output logic wake_r, // leave wait or halt, high while a request can be taken in wait, or a halt-capable one in halt
  output logic busy_r, // entry or return sequence running
  output logic [NUM_VEC-1:0] pend_r // pending latches
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam int NPINS = EXT_LINES * PINS_PER_LINE;
  nic_state_t state_r;
  nic_state_t state_nxt;
  logic [7:0] prio_reg_r [NUM_PRIO_REG];
  logic [7:0] cc_r;
  logic [NPINS-1:0] pin_meta_r;
  logic [NPINS-1:0] pin_sync_r;
  logic [EXT_LINES-1:0] line_r;
  logic [EXT_LINES-1:0] line_now;
  logic [EXT_LINES-1:0] line_rise;
  logic trap_pend_r;
  logic halt_wake_r;
  logic sel_trap_r;
  logic [VEC_IDX_W-1:0] sel_idx_r;
  logic [2:0] step_r;
  logic [NUM_VEC-1:0] pend_set;
  logic [NUM_VEC-1:0] pend_clr;
  logic [NUM_VEC-1:0] cand;
  logic [1:0] vcode [NUM_VEC];
  logic [1:0] cur_lvl;
  logic best_valid;
  logic [VEC_IDX_W-1:0] best_idx;
  logic [1:0] best_lvl;
  logic entry_take;
  logic entry_done;
  logic [1:0] new_code;

  assign condition_code_reg = cc_r;

  // ----------------------------------------------------------------
  // external lines: sync, pin OR, rising edge
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
      line_r <= '0;
    end else begin
      pin_meta_r <= ext_pin;
      pin_sync_r <= pin_meta_r;
      line_r <= line_now;
    end
  end

  always_comb begin
    line_now = '0;
    for (int l = 0; l < EXT_LINES; l++) begin
      line_now[l] = |(pin_sync_r[l*PINS_PER_LINE +: PINS_PER_LINE] &
                      ext_pin_sel[l*PINS_PER_LINE +: PINS_PER_LINE]);
    end
    line_rise = line_now & ~line_r;
  end

  // ----------------------------------------------------------------
  // pending latches
  // ----------------------------------------------------------------
  always_comb begin
    pend_set = (periph_flag & periph_en & ~EDGE_MASK) |
               (NUM_VEC'(line_rise) << EXT_FIRST_VEC);
    pend_clr = periph_clr & ~EDGE_MASK;
    if (entry_done && !sel_trap_r && EDGE_MASK[sel_idx_r]) begin
      pend_clr[sel_idx_r] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pend_r <= '0;
    end else begin
      pend_r <= (pend_r & ~pend_clr) | pend_set;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      trap_pend_r <= 1'b0;
    end else begin
      trap_pend_r <= (trap_pend_r & ~(entry_done & sel_trap_r)) | trap_exec;
    end
  end

  // ----------------------------------------------------------------
  // software priority registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      for (int r = 0; r < NUM_PRIO_REG; r++) begin
        prio_reg_r[r] <= PRIO_REG_RESET;
      end
    end else if (prio_wr) begin
      for (int f = 0; f < FIELDS_PER_REG; f++) begin
        if (prio_wdata[f*2 +: 2] != CODE_LVL0) begin
          prio_reg_r[prio_addr][f*2 +: 2] <= prio_wdata[f*2 +: 2];
        end
      end
      if (prio_addr == PRIO_REG_IDX_W'(NUM_PRIO_REG - 1)) begin
        prio_reg_r[prio_addr][7:4] <= PRIO_REG3_RO_ONES[7:4];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      prio_rdata_r <= '0;
    end else begin
      prio_rdata_r <= prio_reg_r[prio_addr];
    end
  end

  // ----------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------
  always_comb begin
    for (int v = 0; v < NUM_VEC; v++) begin
      vcode[v] = prio_reg_r[v / FIELDS_PER_REG][(v % FIELDS_PER_REG)*2 +: 2];
    end
    cur_lvl = nic_level({cc_r[CC_I1_BIT], cc_r[CC_I0_BIT]});
    cand = pend_r & vec_en;
    if (halt_mode || halt_wake_r) begin
      cand = cand & HALT_MASK;
    end
    best_valid = 1'b0;
    best_idx = '0;
    best_lvl = '0;
    // lower index is higher hardware priority, so ties keep the first
    for (int v = 0; v < NUM_VEC; v++) begin
      if (cand[v] && nic_level(vcode[v]) > cur_lvl &&
          (!best_valid || nic_level(vcode[v]) > best_lvl)) begin
        best_valid = 1'b1;
        best_idx = VEC_IDX_W'(v);
        best_lvl = nic_level(vcode[v]);
      end
    end
  end

  assign entry_take = (state_r == S_IDLE) && !return_from_handler_instr_exec && (trap_pend_r || best_valid);
  assign entry_done = (state_r == S_VEC);
  assign new_code = sel_trap_r ? CODE_LVL3 : vcode[sel_idx_r];

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_RSTV: state_nxt = S_IDLE;
      S_IDLE: begin
        if (return_from_handler_instr_exec) begin
          state_nxt = S_POP;
        end else if (entry_take) begin
          state_nxt = S_DRAIN;
        end
      end
      S_DRAIN: begin
        if (instr_done || wait_mode || halt_mode) begin
          state_nxt = S_PUSH;
        end
      end
      S_PUSH: begin
        if (step_r == STK_LAST) begin
          state_nxt = S_VEC;
        end
      end
      S_VEC: state_nxt = S_IDLE;
      S_POP: begin
        if (step_r == STK_LAST) begin
          state_nxt = S_IDLE;
        end
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_r <= S_RSTV;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sel_trap_r <= 1'b0;
      sel_idx_r <= '0;
    end else if (entry_take) begin
      sel_trap_r <= trap_pend_r;
      sel_idx_r <= best_idx;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      step_r <= '0;
    end else if ((state_r == S_PUSH || state_r == S_POP) && step_r != STK_LAST) begin
      step_r <= step_r + 3'h1;
    end else begin
      step_r <= '0;
    end
  end

  // ----------------------------------------------------------------
  // stack and vector outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      stack_push_r <= 1'b0;
      stack_pop_r <= 1'b0;
      stack_sel_r <= STK_PCL;
    end else begin
      stack_push_r <= (state_nxt == S_PUSH);
      stack_pop_r <= (state_nxt == S_POP);
      if (state_nxt == S_PUSH) begin
        stack_sel_r <= (state_r == S_PUSH) ? stack_sel_r + 3'h1 : STK_PCL;
      end else if (state_nxt == S_POP) begin
        stack_sel_r <= (state_r == S_POP) ? stack_sel_r - 3'h1 : STK_CC;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      vec_load_r <= 1'b0;
      vec_addr_r <= VEC_ADDR_RESET;
    end else begin
      vec_load_r <= (state_r == S_RSTV) || entry_done;
      if (state_r == S_RSTV) begin
        vec_addr_r <= VEC_ADDR_RESET;
      end else if (entry_done) begin
        vec_addr_r <= sel_trap_r ? VEC_ADDR_TRAP :
                      VEC_ADDR_BASE - {11'h000, sel_idx_r, 1'b0};
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      busy_r <= 1'b1;
    end else begin
      busy_r <= (state_nxt != S_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // condition code register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cc_r <= CC_RESET;
    end else if (entry_done) begin
      cc_r[CC_I1_BIT] <= new_code[1];
      cc_r[CC_I0_BIT] <= new_code[0];
    end else if (state_r == S_POP && step_r == '0) begin
      cc_r <= pop_data | CC_FIXED_ONES;
    end else if (cc_wr) begin
      cc_r <= cc_wdata | CC_FIXED_ONES;
    end
  end

  // ----------------------------------------------------------------
  // wake-up from low power modes
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wake_r <= 1'b0;
      halt_wake_r <= 1'b0;
    end else begin
      wake_r <= (wait_mode || halt_mode) && (best_valid || trap_pend_r);
      if (halt_mode && (best_valid || trap_pend_r)) begin
        halt_wake_r <= 1'b1;
      end else if (entry_done) begin
        halt_wake_r <= 1'b0;
      end
    end
  end
endmodule : nic_ctrl

//--- hw/nic_pkg.sv
// constants and helpers shared by the nested interrupt controller
package nic_pkg;
  // ----------------------------------------------------------------
  // vector map
  // ----------------------------------------------------------------
  localparam int NUM_VEC = 14;
  localparam int VEC_IDX_W = 4;
  localparam int NUM_PRIO_REG = 4;
  localparam int PRIO_REG_IDX_W = 2;
  localparam int FIELDS_PER_REG = 4;
  localparam logic [15:0] VEC_ADDR_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_ADDR_TRAP = 16'hFFFC;
  localparam logic [15:0] VEC_ADDR_BASE = 16'hFFFA;
  localparam logic [NUM_VEC-1:0] EDGE_MASK_DEF = 14'h003C;
  localparam logic [NUM_VEC-1:0] HALT_MASK_DEF = 14'h00BC;
  localparam int EXT_LINES = 4;
  localparam int EXT_FIRST_VEC = 2;
  localparam int PINS_PER_LINE = 4;
  // ----------------------------------------------------------------
  // condition code and priority fields
  // ----------------------------------------------------------------
  localparam int CC_I1_BIT = 5;
  localparam int CC_I0_BIT = 3;
  localparam logic [7:0] CC_RESET = 8'hEA;
  localparam logic [7:0] CC_FIXED_ONES = 8'hC0;
  localparam logic [7:0] PRIO_REG_RESET = 8'hFF;
  localparam logic [7:0] PRIO_REG3_RO_ONES = 8'hF0;
  localparam logic [1:0] CODE_LVL0 = 2'h2;
  localparam logic [1:0] CODE_LVL1 = 2'h1;
  localparam logic [1:0] CODE_LVL2 = 2'h0;
  localparam logic [1:0] CODE_LVL3 = 2'h3;
  // ----------------------------------------------------------------
  // context stacking
  // ----------------------------------------------------------------
  localparam int STACK_BYTES = 5;
  localparam logic [2:0] STK_PCL = 3'h0;
  localparam logic [2:0] STK_PCH = 3'h1;
  localparam logic [2:0] STK_X = 3'h2;
  localparam logic [2:0] STK_A = 3'h3;
  localparam logic [2:0] STK_CC = 3'h4;
  localparam logic [2:0] STK_LAST = 3'h4;

  typedef enum logic [5:0] {
    S_RSTV  = 6'h01,
    S_IDLE  = 6'h02,
    S_DRAIN = 6'h04,
    S_PUSH  = 6'h08,
    S_VEC   = 6'h10,
    S_POP   = 6'h20
  } nic_state_t;

  // priority code {I1,I0} to numeric level, 0 lowest
  function automatic logic [1:0] nic_level(input logic [1:0] code);
    case (code)
      CODE_LVL0: nic_level = 2'h0;
      CODE_LVL1: nic_level = 2'h1;
      CODE_LVL2: nic_level = 2'h2;
      default: nic_level = 2'h3;
    endcase
  endfunction : nic_level
endpackage : nic_pkg

//--- verif/nic_cpu_model.sv
// behavioural cpu core facing the controller: instruction end and stack
`timescale 1ns/100ps
module nic_cpu_model import nic_pkg::*; #(
  parameter int DONE_DLY = 2
) (
  input wire logic sys_clk, // cpu clock
  input wire logic reset, // async reset
  input wire logic busy_r, // controller sequence running
  input wire logic stack_push_r, // push strobe
  input wire logic stack_pop_r, // pop strobe
  input wire logic [2:0] stack_sel_r, // context byte
  input wire logic [7:0] condition_code_reg, // cc to save
  output logic instr_done, // instruction ends
  output logic [7:0] pop_data // popped byte
);
  logic [7:0] cc_q[$];
  int cnt;
  always @(negedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt = 0;
      instr_done <= 1'b0;
      pop_data <= 8'h00;
      cc_q.delete();
    end else begin
      instr_done <= 1'b0;
      if (busy_r && !stack_push_r && !stack_pop_r) begin
        cnt = cnt + 1;
        if (cnt == DONE_DLY) instr_done <= 1'b1;
      end else begin
        cnt = 0;
      end
      if (stack_push_r && stack_sel_r == STK_CC) cc_q.push_back(condition_code_reg);
      if (stack_pop_r && stack_sel_r == STK_CC && cc_q.size() > 0) begin
        pop_data <= cc_q.pop_back();
      end else begin
        pop_data <= ~pop_data;
      end
    end
  end
endmodule : nic_cpu_model

//--- verif/nic_ctrl_monitor.sv
// port-level assertions for the interrupt controller
`timescale 1ns/100ps
module nic_ctrl_monitor import nic_pkg::*; (
  input wire logic sys_clk, // clock
  input wire logic reset, // reset
  input wire logic wait_mode, // wait level
  input wire logic halt_mode, // halt level
  input wire logic [7:0] condition_code_reg, // cc
  input wire logic stack_push_r, // push
  input wire logic stack_pop_r, // pop
  input wire logic [2:0] stack_sel_r, // byte select
  input wire logic vec_load_r, // vector load
  input wire logic [15:0] vec_addr_r, // vector
  input wire logic wake_r, // wake
  input wire logic busy_r, // busy
  input wire logic [NUM_VEC-1:0] pend_r // pending
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  push_run_a: assert property ($rose(stack_push_r) |-> stack_push_r [*5] ##1 !stack_push_r)
    else $error("push run not five bytes");
  push_first_a: assert property ($rose(stack_push_r) |-> stack_sel_r == STK_PCL)
    else $error("push does not start at pc low");
  push_seq_a: assert property (stack_push_r && stack_sel_r != STK_LAST
    |=> stack_sel_r == $past(stack_sel_r) + 3'h1) else $error("push order broken");
  pop_run_a: assert property ($rose(stack_pop_r) |-> stack_sel_r == STK_CC
    ##1 stack_pop_r [*4] ##1 !stack_pop_r) else $error("pop run wrong");
  vec_follow_a: assert property ($fell(stack_push_r) |=> vec_load_r)
    else $error("no vector load after stacking");
  vec_map_a: assert property (vec_load_r |-> vec_addr_r >= 16'hFFE0 && !vec_addr_r[0])
    else $error("vector outside map");
  nmi_level_a: assert property (vec_load_r && vec_addr_r >= VEC_ADDR_TRAP
    |-> condition_code_reg[CC_I1_BIT] && condition_code_reg[CC_I0_BIT])
    else $error("non-maskable entry not at level 3");
  cc_ones_a: assert property (condition_code_reg[7:6] == 2'h3)
    else $error("cc top bits not one");
  entry_idle_a: assert property (vec_load_r |-> !busy_r)
    else $error("busy at vector load");
  wake_mode_a: assert property (wake_r |-> $past(wait_mode) || $past(halt_mode))
    else $error("wake while not sleeping");
  edge_clear_a: assert property (vec_load_r && vec_addr_r == 16'hFFF6 |-> !pend_r[2])
    else $error("edge latch kept on entry");
endmodule : nic_ctrl_monitor
bind nic_ctrl nic_ctrl_monitor mon (.sys_clk, .reset, .wait_mode, .halt_mode,
  .condition_code_reg, .stack_push_r, .stack_pop_r, .stack_sel_r, .vec_load_r,
  .vec_addr_r, .wake_r, .busy_r, .pend_r);

//--- verif/nic_ctrl_bench.sv
// self-checking bench for the nested interrupt controller
`timescale 1ns/100ps
module nic_ctrl_bench import nic_pkg::*;;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [15:0] ext_pin, ext_pin_sel, vec_addr_r;
  logic [NUM_VEC-1:0] periph_flag, periph_en, periph_clr, vec_en, pend_r;
  logic instr_done, trap_exec, return_from_handler_instr_exec, wait_mode, halt_mode, cc_wr, prio_wr;
  logic [7:0] cc_wdata, pop_data, prio_wdata, prio_rdata_r, condition_code_reg;
  logic [1:0] prio_addr;
  logic stack_push_r, stack_pop_r, vec_load_r, wake_r, busy_r;
  logic [2:0] stack_sel_r;
  int fail_count = 0;
  int num_checks = 0;
  int k;
  always #5 sys_clk = ~sys_clk;
  nic_ctrl dut (.sys_clk, .reset, .ext_pin, .ext_pin_sel, .periph_flag, .periph_en,
    .periph_clr, .vec_en, .instr_done, .trap_exec, .return_from_handler_instr_exec, .wait_mode, .halt_mode,
    .cc_wr, .cc_wdata, .pop_data, .prio_wr, .prio_addr, .prio_wdata, .prio_rdata_r,
    .condition_code_reg, .stack_push_r, .stack_pop_r, .stack_sel_r, .vec_load_r,
    .vec_addr_r, .wake_r, .busy_r, .pend_r);
  nic_cpu_model #(.DONE_DLY(3)) cpu (.sys_clk, .reset, .busy_r, .stack_push_r,
    .stack_pop_r, .stack_sel_r, .condition_code_reg, .instr_done, .pop_data);
  task automatic summarize;
    if (fail_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize
  task automatic tick;
    @(negedge sys_clk);
  endtask : tick
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic lvl(input logic [1:0] code);
    chk({14'h0000, condition_code_reg[CC_I1_BIT], condition_code_reg[CC_I0_BIT]},
      {14'h0000, code});
  endtask : lvl
  task automatic wait_vec(input logic [15:0] exp);
    int i;
    for (i = 0; i < 200 && vec_load_r !== 1'b1; i++) tick();
    if (i == 200) begin
      fail_count++;
      $display("MISMATCH %0t no vector load", $time);
      summarize();
    end
    chk(vec_addr_r, exp);
    tick();
  endtask : wait_vec
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    prio_wr = 1'b1;
    prio_addr = a;
    prio_wdata = d;
    tick();
    prio_wr = 1'b0;
    tick();
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    prio_addr = a;
    tick();
    chk({8'h00, prio_rdata_r}, {8'h00, exp});
  endtask : rd
  task automatic set_cc(input logic [7:0] d);
    cc_wr = 1'b1;
    cc_wdata = d;
    tick();
    cc_wr = 1'b0;
  endtask : set_cc
  initial begin
    ext_pin = '0;
    ext_pin_sel = 16'h0012;
    {periph_flag, periph_clr} = '0;
    {periph_en, vec_en} = '1;
    {trap_exec, return_from_handler_instr_exec, wait_mode, halt_mode, cc_wr, prio_wr} = '0;
    {cc_wdata, prio_wdata, prio_addr} = '0;
    repeat (10) tick();
    reset = 1'b0;
    chk({8'h00, condition_code_reg}, {8'h00, CC_RESET});
    wait_vec(VEC_ADDR_RESET);
    for (int r = 0; r < NUM_PRIO_REG; r++) rd(r[1:0], PRIO_REG_RESET);
    wr(2'h0, 8'hCF);
    wr(2'h0, 8'h64);
    rd(2'h0, 8'h44);
    wr(2'h3, 8'h00);
    rd(2'h3, PRIO_REG3_RO_ONES);
    wr(2'h0, 8'h1F);
    wr(2'h1, 8'h7F);
    wr(2'h2, 8'hF0);
    set_cc(8'hE2);
    ext_pin[0] = 1'b1;
    ext_pin[1] = 1'b1;
    wait_vec(16'hFFF6);
    lvl(CODE_LVL1);
    chk({15'h0000, pend_r[2]}, 16'h0000);
    periph_flag = 14'h0380;
    wait_vec(16'hFFEA);
    lvl(CODE_LVL2);
    chk({2'h0, pend_r}, 16'h0380);
    periph_flag = '0;
    tick();
    periph_clr = 14'h0100;
    tick();
    periph_clr = '0;
    return_from_handler_instr_exec = 1'b1;
    tick();
    return_from_handler_instr_exec = 1'b0;
    wait_vec(16'hFFE8);
    periph_clr = 14'h0280;
    tick();
    periph_clr = '0;
    tick();
    chk({2'h0, pend_r}, 16'h0000);
    set_cc(CC_RESET);
    periph_flag = 14'h0080;
    repeat (4) tick();
    trap_exec = 1'b1;
    tick();
    trap_exec = 1'b0;
    wait_vec(VEC_ADDR_TRAP);
    lvl(CODE_LVL3);
    chk({15'h0000, pend_r[7]}, 16'h0001);
    periph_flag = '0;
    tick();
    periph_clr = 14'h0080;
    tick();
    periph_clr = '0;
    set_cc(8'hE2);
    vec_en[7] = 1'b0;
    wait_mode = 1'b1;
    periph_flag = 14'h0080;
    repeat (4) tick();
    chk({14'h0000, wake_r, busy_r}, 16'h0000);
    vec_en[7] = 1'b1;
    tick();
    chk({15'h0000, wake_r}, 16'h0001);
    wait_mode = 1'b0;
    wait_vec(16'hFFEC);
    lvl(CODE_LVL1);
    halt_mode = 1'b1;
    periph_flag = 14'h0002;
    repeat (6) tick();
    chk({15'h0000, wake_r}, 16'h0000);
    ext_pin[4] = 1'b1;
    for (k = 0; k < 50 && wake_r !== 1'b1; k++) tick();
    if (k == 50) begin
      fail_count++;
      $display("MISMATCH %0t no wake from halt", $time);
      summarize();
    end
    chk({15'h0000, wake_r}, 16'h0001);
    halt_mode = 1'b0;
    wait_vec(16'hFFF4);
    wait_vec(16'hFFF8);
    summarize();
  end
endmodule : nic_ctrl_bench
